// ==== mpi_interp.sv ====
`timescale 1ns/1ps
module mpi_interp (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic run_mode,
  output logic [15:0] prog_addr,
  output logic prog_rd,
  input wire logic prog_valid,
  input wire logic [63:0] prog_cmd,
  input wire logic [31:0] accum,
  input wire logic [31:0] actual_pos,
  output logic [7:0] stored_point_kind_idx,
  input wire logic [31:0] stored_point_kind_pos,
  input wire logic flag_zero,
  input wire logic flag_equal,
  input wire logic flag_above,
  input wire logic [3:0] err_flags,
  input wire logic target_reached,
  output logic ap_wr,
  output logic [7:0] ap_idx,
  output logic [31:0] ap_data,
  output logic vel_mode,
  output logic spin_left,
  output logic move_busy,
  output logic [3:0] stk_level
);
  mpi_stk_if stk ();
  mpi_rstk_mem u_mem (.clk_sys(clk_sys), .stk(stk));

  function automatic logic [7:0] sum8(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = 8'(s + b[i*8 +: 8]);
    end
    return s;
  endfunction : sum8

  function automatic logic [7:0] reply_byte(input logic [63:0] r, input logic [3:0] idx);
    logic [7:0] v;
    v = sum8(r);
    for (int i = 0; i < 8; i++) begin
      if (idx == 4'(i)) begin
        v = r[(7-i)*8 +: 8];
      end
    end
    return v;
  endfunction : reply_byte

  // receive assembler
  logic [63:0] rx_buf_ff, nxt_rx_buf;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic pkt_rdy_ff, nxt_pkt_rdy;
  logic [63:0] pkt_ff, nxt_pkt;
  logic take;

  always_comb begin
    nxt_rx_buf = rx_buf_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_pkt = pkt_ff;
    nxt_pkt_rdy = pkt_rdy_ff & ~take;
    if (rx_valid) begin
      if (rx_cnt_ff != mpi_pkg::PKT_LAST) begin
        nxt_rx_buf = {rx_buf_ff[55:0], rx_byte};
        nxt_rx_cnt = 4'(rx_cnt_ff + 4'h1);
      end else begin
        nxt_rx_cnt = 4'h0;
        // checksum gate
        // a new packet wins over a same-cycle take
        if (rx_byte == sum8(rx_buf_ff) && rx_buf_ff[63:56] == mpi_pkg::MOD_ADDR) begin
          nxt_pkt_rdy = 1'b1;
          nxt_pkt = rx_buf_ff;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_buf_ff <= 64'h0;
      rx_cnt_ff <= 4'h0;
      pkt_rdy_ff <= 1'b0;
      pkt_ff <= 64'h0;
    end else begin
      rx_buf_ff <= nxt_rx_buf;
      rx_cnt_ff <= nxt_rx_cnt;
      pkt_rdy_ff <= nxt_pkt_rdy;
      pkt_ff <= nxt_pkt;
    end
  end

  // interpreter
  mpi_pkg::mpi_state_t state_ff, nxt_state;
  logic [15:0] pc_ff, nxt_pc;
  logic [3:0] sp_ff, nxt_sp;
  logic [7:0] op_ff, nxt_op, typ_ff, nxt_typ, bank_ff, nxt_bank;
  logic [31:0] val_ff, nxt_val;
  logic direct_ff, nxt_direct;
  logic [63:0] rep_ff, nxt_rep;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [7:0] tx_byte_ff, nxt_tx_byte;
  logic tx_valid_ff, nxt_tx_valid, prog_rd_ff, nxt_prog_rd;
  logic [7:0] stored_point_kind_idx_ff, nxt_stored_point_kind_idx, ap_idx_ff, nxt_ap_idx;
  logic ap_wr_ff, nxt_ap_wr, vel_mode_ff, nxt_vel_mode;
  logic spin_left_ff, nxt_spin_left, move_busy_ff, nxt_move_busy;
  logic [31:0] ap_data_ff, nxt_ap_data;
  logic cond_hit;
  logic [31:0] tgt;

  always_comb begin
    unique case (typ_ff[3:0])
      mpi_pkg::COND_IS_NULL: cond_hit = flag_zero;
      mpi_pkg::COND_NON_NULL: cond_hit = ~flag_zero;
      mpi_pkg::COND_MATCH: cond_hit = flag_equal;
      mpi_pkg::COND_DIFFER: cond_hit = ~flag_equal;
      mpi_pkg::COND_ABOVE: cond_hit = flag_above;
      mpi_pkg::COND_ABOVE_MATCH: cond_hit = flag_above | flag_equal;
      mpi_pkg::COND_BELOW: cond_hit = ~flag_above & ~flag_equal;
      mpi_pkg::COND_BELOW_MATCH: cond_hit = ~flag_above;
      mpi_pkg::COND_TIMEOUT: cond_hit = err_flags[0];
      mpi_pkg::COND_ALARM: cond_hit = err_flags[1];
      mpi_pkg::COND_DRIFT: cond_hit = err_flags[2];
      mpi_pkg::COND_PLACE: cond_hit = err_flags[3];
      default: cond_hit = 1'b0;
    endcase
    if (typ_ff[7:4] != 4'h0) begin
      cond_hit = 1'b0;
    end
  end

  // target forming, wraps at 32 bits
  always_comb begin
    unique case (typ_ff)
      mpi_pkg::KIND_OFFSET: tgt = 32'(accum + actual_pos);
      mpi_pkg::KIND_POINT: tgt = stored_point_kind_pos;
      default: tgt = accum;
    endcase
  end

  always_comb begin
    logic [7:0] st;
    logic [31:0] rv;
    st = mpi_pkg::ST_OK;
    rv = val_ff;
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_op = op_ff;
    nxt_typ = typ_ff;
    nxt_bank = bank_ff;
    nxt_val = val_ff;
    nxt_direct = direct_ff;
    nxt_rep = rep_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_byte = tx_byte_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_prog_rd = 1'b0;
    nxt_stored_point_kind_idx = stored_point_kind_idx_ff;
    nxt_ap_wr = 1'b0;
    nxt_ap_idx = ap_idx_ff;
    nxt_ap_data = ap_data_ff;
    nxt_vel_mode = vel_mode_ff;
    nxt_spin_left = spin_left_ff;
    nxt_move_busy = move_busy_ff & ~target_reached;
    take = 1'b0;
    stk.we = 1'b0;
    stk.addr = sp_ff[2:0];
    stk.wdata = 16'(pc_ff + 16'h0001);
    unique case (state_ff)
      mpi_pkg::S_IDLE: begin
        // direct packets have priority over the stored program
        if (pkt_rdy_ff) begin
          take = 1'b1;
          {nxt_op, nxt_typ, nxt_bank, nxt_val} = pkt_ff[55:0];
          nxt_stored_point_kind_idx = pkt_ff[39:32];
          nxt_direct = 1'b1;
          nxt_state = mpi_pkg::S_EXEC;
        end else if (run_mode) begin
          nxt_prog_rd = 1'b1;
          nxt_state = mpi_pkg::S_FETCH;
        end
      end
      mpi_pkg::S_FETCH: begin
        if (prog_valid) begin
          {nxt_op, nxt_typ, nxt_bank, nxt_val} = prog_cmd[55:0];
          nxt_stored_point_kind_idx = prog_cmd[39:32];
          nxt_direct = 1'b0;
          nxt_state = mpi_pkg::S_EXEC;
        end
      end
      mpi_pkg::S_EXEC: begin
        nxt_state = mpi_pkg::S_IDLE;
        if (!direct_ff) begin
          // default is the next stored command
          nxt_pc = 16'(pc_ff + 16'h0001);
        end
        unique case (op_ff)
          mpi_pkg::OP_CALL: begin
            if (direct_ff) begin
              st = mpi_pkg::ST_BAD_CMD;
            // push then jump, full stack ignores
            end else if (cond_hit && sp_ff < mpi_pkg::STK_DEPTH) begin
              stk.we = 1'b1;
              nxt_sp = 4'(sp_ff + 4'h1);
              nxt_pc = val_ff[15:0];
            end
          end
          mpi_pkg::OP_RET: begin
            if (direct_ff) begin
              st = mpi_pkg::ST_BAD_CMD;
            end else if (sp_ff != 4'h0) begin
              stk.addr = 3'(sp_ff - 4'h1);
              nxt_sp = 4'(sp_ff - 4'h1);
              nxt_state = mpi_pkg::S_POP;
            end
          end
          mpi_pkg::OP_MOVE_ACC: begin
            if (typ_ff > mpi_pkg::KIND_POINT) begin
              st = mpi_pkg::ST_BAD_TYPE;
            end else begin
              nxt_ap_wr = 1'b1;
              nxt_ap_idx = mpi_pkg::AP_TGT_POS;
              nxt_ap_data = tgt;
              nxt_vel_mode = 1'b0;
              nxt_move_busy = 1'b1;
              rv = tgt;
            end
          end
          mpi_pkg::OP_SPIN_L_ACC: begin
            nxt_vel_mode = 1'b1;
            nxt_spin_left = 1'b1;
            nxt_move_busy = 1'b0;
            nxt_ap_wr = 1'b1;
            nxt_ap_idx = mpi_pkg::AP_TGT_VEL;
            nxt_ap_data = accum;
            rv = accum;
          end
          mpi_pkg::OP_HALT, mpi_pkg::OP_SPIN_L, mpi_pkg::OP_SPIN_R: begin
            nxt_move_busy = 1'b0;
          end
          default: begin
          end
        endcase
        if (direct_ff) begin
          nxt_rep = {mpi_pkg::HOST_ADDR, mpi_pkg::MOD_ADDR, st, op_ff, rv};
          nxt_tx_byte = mpi_pkg::HOST_ADDR;
          nxt_tx_valid = 1'b1;
          nxt_tx_cnt = 4'h0;
          nxt_state = mpi_pkg::S_REPLY;
        end
      end
      mpi_pkg::S_POP: begin
        nxt_pc = stk.rdata;
        nxt_state = mpi_pkg::S_IDLE;
      end
      mpi_pkg::S_REPLY: begin
        if (tx_ready) begin
          if (tx_cnt_ff == mpi_pkg::PKT_LAST) begin
            nxt_tx_valid = 1'b0;
            nxt_state = mpi_pkg::S_IDLE;
          end else begin
            nxt_tx_cnt = 4'(tx_cnt_ff + 4'h1);
            nxt_tx_byte = reply_byte(rep_ff, 4'(tx_cnt_ff + 4'h1));
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= mpi_pkg::S_IDLE;
      pc_ff <= 16'h0000;
      sp_ff <= 4'h0;
      op_ff <= 8'h00;
      typ_ff <= 8'h00;
      bank_ff <= 8'h00;
      val_ff <= 32'h0;
      direct_ff <= 1'b0;
      rep_ff <= 64'h0;
      tx_cnt_ff <= 4'h0;
      tx_byte_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      prog_rd_ff <= 1'b0;
      stored_point_kind_idx_ff <= 8'h00;
      ap_wr_ff <= 1'b0;
      ap_idx_ff <= 8'h00;
      ap_data_ff <= 32'h0;
      vel_mode_ff <= 1'b0;
      spin_left_ff <= 1'b0;
      move_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      op_ff <= nxt_op;
      typ_ff <= nxt_typ;
      bank_ff <= nxt_bank;
      val_ff <= nxt_val;
      direct_ff <= nxt_direct;
      rep_ff <= nxt_rep;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_byte_ff <= nxt_tx_byte;
      tx_valid_ff <= nxt_tx_valid;
      prog_rd_ff <= nxt_prog_rd;
      stored_point_kind_idx_ff <= nxt_stored_point_kind_idx;
      ap_wr_ff <= nxt_ap_wr;
      ap_idx_ff <= nxt_ap_idx;
      ap_data_ff <= nxt_ap_data;
      vel_mode_ff <= nxt_vel_mode;
      spin_left_ff <= nxt_spin_left;
      move_busy_ff <= nxt_move_busy;
    end
  end

  assign tx_byte = tx_byte_ff;
  assign tx_valid = tx_valid_ff;
  assign prog_addr = pc_ff;
  assign prog_rd = prog_rd_ff;
  assign stored_point_kind_idx = stored_point_kind_idx_ff;
  assign ap_wr = ap_wr_ff;
  assign ap_idx = ap_idx_ff;
  assign ap_data = ap_data_ff;
  assign vel_mode = vel_mode_ff;
  assign spin_left = spin_left_ff;
  assign move_busy = move_busy_ff;
  assign stk_level = sp_ff;

  logic ex_call, ex_move;
  assign ex_call = state_ff == mpi_pkg::S_EXEC && op_ff == mpi_pkg::OP_CALL;
  assign ex_move = state_ff == mpi_pkg::S_EXEC && op_ff == mpi_pkg::OP_MOVE_ACC;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_call_taken_jump: assert property (ex_call && !direct_ff && cond_hit && sp_ff < 4'h8
    |=> pc_ff == 16'($past(val_ff)) && sp_ff == 4'($past(sp_ff) + 4'h1))
    else $error("taken branch did not push and jump");
  a_call_false_step: assert property (ex_call && !direct_ff && !cond_hit
    |=> pc_ff == 16'($past(pc_ff) + 16'h0001) && $stable(sp_ff))
    else $error("false branch did not just advance");
  a_stack_full_skip: assert property (ex_call && !direct_ff && sp_ff == 4'h8
    |=> sp_ff == 4'h8 && pc_ff == 16'($past(pc_ff) + 16'h0001))
    else $error("branch on full stack not ignored");
  a_stack_depth_cap: assert property (sp_ff <= 4'h8)
    else $error("return stack beyond eight");
  a_call_direct_refuse: assert property (ex_call && direct_ff
    |=> $stable(sp_ff) && rep_ff[47:40] == 8'h02)
    else $error("direct branch not refused");
  a_move_fixed_write: assert property (ex_move && typ_ff == 8'h00
    |=> ap_wr && ap_idx == 8'h00 && ap_data == $past(accum) && move_busy)
    else $error("fixed move target wrong");
  a_move_offset_wrap: assert property (ex_move && typ_ff == 8'h01
    |=> ap_data == 32'($past(accum) + $past(actual_pos)))
    else $error("offset move target wrong");
  a_spin_left_vel: assert property (state_ff == mpi_pkg::S_EXEC
    && op_ff == mpi_pkg::OP_SPIN_L_ACC
    |=> vel_mode && spin_left && ap_wr && ap_idx == 8'h02 && ap_data == $past(accum))
    else $error("left spin velocity write wrong");
  a_reply_at_once: assert property (ex_move && direct_ff
    |=> tx_valid && tx_byte == 8'h02 ##1 state_ff == mpi_pkg::S_REPLY)
    else $error("move reply not immediate");
  a_halt_aborts_move: assert property (state_ff == mpi_pkg::S_EXEC && op_ff == 8'h03
    |=> !move_busy)
    else $error("halt did not abort move");

  c_call_taken: cover property (ex_call && cond_hit && sp_ff < 4'h8);
  c_stack_full: cover property (ex_call && cond_hit && sp_ff == 4'h8);
  c_reply_done: cover property (state_ff == mpi_pkg::S_REPLY && tx_ready && tx_cnt_ff == 4'h8);
  c_offset_move: cover property (ex_move && typ_ff == 8'h01);
endmodule : mpi_interp

// ==== mpi_pkg.sv ====
package mpi_pkg;
  // opcodes
  localparam logic [7:0] OP_SPIN_R = 8'h01;
  localparam logic [7:0] OP_SPIN_L = 8'h02;
  localparam logic [7:0] OP_HALT = 8'h03;
  localparam logic [7:0] OP_CALL = 8'h15;
  localparam logic [7:0] OP_RET = 8'h16;
  localparam logic [7:0] OP_MOVE_ACC = 8'h2E;
  localparam logic [7:0] OP_SPIN_L_ACC = 8'h32;
  // branch condition codes
  localparam logic [3:0] COND_IS_NULL = 4'h0;
  localparam logic [3:0] COND_NON_NULL = 4'h1;
  localparam logic [3:0] COND_MATCH = 4'h2;
  localparam logic [3:0] COND_DIFFER = 4'h3;
  localparam logic [3:0] COND_ABOVE = 4'h4;
  localparam logic [3:0] COND_ABOVE_MATCH = 4'h5;
  localparam logic [3:0] COND_BELOW = 4'h6;
  localparam logic [3:0] COND_BELOW_MATCH = 4'h7;
  localparam logic [3:0] COND_TIMEOUT = 4'h8;
  localparam logic [3:0] COND_ALARM = 4'h9;
  localparam logic [3:0] COND_DRIFT = 4'hA;
  localparam logic [3:0] COND_PLACE = 4'hB;
  // move kinds
  localparam logic [7:0] KIND_FIXED = 8'h00;
  localparam logic [7:0] KIND_OFFSET = 8'h01;
  localparam logic [7:0] KIND_POINT = 8'h02;
  // axis parameter indices
  localparam logic [7:0] AP_TGT_POS = 8'h00;
  localparam logic [7:0] AP_TGT_VEL = 8'h02;
  // reply status
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  // packet layout
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [7:0] MOD_ADDR = 8'h01;
  localparam logic [3:0] PKT_LAST = 4'h8;
  // return stack and interpreter states
  localparam int PC_W = 16;
  localparam int STK_AW = 3;
  localparam logic [3:0] STK_DEPTH = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EXEC, S_POP, S_REPLY} mpi_state_t;
endpackage : mpi_pkg

// ==== mpi_stk_if.sv ====
`timescale 1ns/1ps
interface mpi_stk_if;
  logic we;
  logic [mpi_pkg::STK_AW-1:0] addr;
  logic [mpi_pkg::PC_W-1:0] wdata;
  logic [mpi_pkg::PC_W-1:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : mpi_stk_if

// ==== mpi_rstk_mem.sv ====
`timescale 1ns/1ps
module mpi_rstk_mem (
  input wire logic clk_sys,
  mpi_stk_if.mem stk
);
  logic [mpi_pkg::PC_W-1:0] mem_ff [0:7];
  logic [mpi_pkg::PC_W-1:0] rdata_ff;

  // no reset: contents are only read below the stack pointer
  always_ff @(posedge clk_sys) begin
    if (stk.we) begin
      mem_ff[stk.addr] <= stk.wdata;
    end
    rdata_ff <= mem_ff[stk.addr];
  end

  assign stk.rdata = rdata_ff;
endmodule : mpi_rstk_mem

// ==== mpi_host_model.sv ====
`timescale 1ns/1ps
module mpi_host_model (
  input wire logic clk_sys,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid
);
  int slow = 0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  task automatic send(input logic [63:0] body, input logic bad);
    logic [71:0] pkt;
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum += body[63-8*i -: 8];
    pkt = {body, sum + {7'h00, bad}};
    for (int i = 0; i < 9; i++) begin
      @(negedge clk_sys);
      rx_byte = pkt[71-8*i -: 8];
      rx_valid = 1'b1;
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    // released line must not show a stale byte
    rx_byte = ~rx_byte;
  endtask : send
  // whole reply taken before next command
  task automatic recv(output logic got, output logic [71:0] raw);
    int n;
    got = 1'b1;
    raw = '0;
    for (int i = 0; i < 9; i++) begin
      n = 0;
      while (tx_valid !== 1'b1 && n < 50) begin
        @(negedge clk_sys);
        n++;
      end
      if (tx_valid !== 1'b1) begin
        got = 1'b0;
        return;
      end
      repeat (slow) @(negedge clk_sys);
      raw[71-8*i -: 8] = tx_byte;
      tx_ready = 1'b1;
      @(negedge clk_sys);
      tx_ready = 1'b0;
    end
  endtask : recv
endmodule : mpi_host_model

// ==== tb_motion_program_interpreter.sv ====
`timescale 1ns/1ps
module tb_motion_program_interpreter;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic run_mode = 1'b0;
  logic prog_valid = 1'b0;
  logic [63:0] prog_cmd = '0;
  logic [31:0] accum = '0;
  logic [31:0] actual_pos = '0;
  logic flag_zero = 1'b0;
  logic flag_equal = 1'b0;
  logic flag_above = 1'b0;
  logic [3:0] err_flags = '0;
  logic target_reached = 1'b0;
  logic [7:0] rx_byte, tx_byte, stored_point_kind_idx, ap_idx, ap_idx_q;
  logic rx_valid, tx_ready, tx_valid, prog_rd, ap_wr, vel_mode, spin_left, move_busy;
  logic [15:0] prog_addr;
  logic [31:0] stored_point_kind_pos, ap_data, ap_data_q;
  logic [3:0] stk_level;
  logic [63:0] pmem [32];
  logic [15:0] flog [$];
  int ap_cnt = 0;
  int errors = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  assign stored_point_kind_pos = {24'hC0DE00, stored_point_kind_idx};
  mpi_host_model u_mpi_host_model (.clk_sys(clk_sys), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid));
  mpi_interp u_mpi_interp (.clk_sys(clk_sys), .rst_n(rst_n), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .run_mode(run_mode), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_valid(prog_valid),
    .prog_cmd(prog_cmd), .accum(accum), .actual_pos(actual_pos), .stored_point_kind_idx(stored_point_kind_idx),
    .stored_point_kind_pos(stored_point_kind_pos), .flag_zero(flag_zero), .flag_equal(flag_equal),
    .flag_above(flag_above), .err_flags(err_flags), .target_reached(target_reached),
    .ap_wr(ap_wr), .ap_idx(ap_idx), .ap_data(ap_data), .vel_mode(vel_mode),
    .spin_left(spin_left), .move_busy(move_busy), .stk_level(stk_level));
  always @(posedge clk_sys) begin
    if (ap_wr === 1'b1) begin
      ap_cnt <= ap_cnt + 1;
      ap_idx_q <= ap_idx;
      ap_data_q <= ap_data;
    end
  end
  always @(negedge clk_sys) begin
    prog_valid <= 1'b0;
    if (prog_rd === 1'b1) begin
      prog_valid <= 1'b1;
      prog_cmd <= pmem[prog_addr[4:0]];
      flog.push_back(prog_addr);
    end
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic conclude();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic do_reset();
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
  endtask : do_reset
  // one direct command; reply fields checked, value only when chkv
  task automatic cmd(input logic [7:0] op, typ, bank, input logic [31:0] val,
    input logic [7:0] st, input logic [31:0] ev, input logic chkv);
    logic got;
    logic [71:0] r;
    logic [7:0] s;
    u_mpi_host_model.send({mpi_pkg::MOD_ADDR, op, typ, bank, val}, 1'b0);
    u_mpi_host_model.recv(got, r);
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += r[71-8*i -: 8];
    chk_val(32'(got), 32'h1);
    chk_val(32'(r[71:48]), {8'h00, mpi_pkg::HOST_ADDR, mpi_pkg::MOD_ADDR, st});
    chk_val(32'(r[47:40]), 32'(op));
    if (chkv) chk_val(r[39:8], ev);
    chk_val(32'(r[7:0]), 32'(s));
  endtask : cmd
  task automatic mv(input logic [7:0] kind, bank, input logic [31:0] tgt);
    cmd(mpi_pkg::OP_MOVE_ACC, kind, bank, 32'h5A5A_A5A5, mpi_pkg::ST_OK, tgt, 1'b1);
    chk_val(32'(ap_idx_q), 32'(mpi_pkg::AP_TGT_POS));
    chk_val(ap_data_q, tgt);
    chk_val({30'h0, move_busy, vel_mode}, 32'h2);
  endtask : mv
  task automatic run_prog(input int n);
    int k;
    flog.delete();
    @(negedge clk_sys);
    run_mode = 1'b1;
    k = 0;
    while (flog.size() < n && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    run_mode = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk_val(32'(flog.size() >= n), 32'h1);
  endtask : run_prog
  function automatic logic [63:0] call_cmd(input logic [3:0] c, input logic [15:0] a);
    // bank field set non-zero: the branch must not look at it
    return {8'h00, mpi_pkg::OP_CALL, 4'h0, c, 8'h3C, 16'h0000, a};
  endfunction : call_cmd
  // expected outcome of each condition code from the flag levels
  function automatic logic cond_exp(input int c);
    logic bl;
    bl = !flag_above && !flag_equal;
    case (c)
      0: return flag_zero;
      1: return !flag_zero;
      2: return flag_equal;
      3: return !flag_equal;
      4: return flag_above;
      5: return flag_above || flag_equal;
      6: return bl;
      7: return bl || flag_equal;
      8, 9, 10, 11: return err_flags[c-8];
      default: return 1'b0;
    endcase
  endfunction : cond_exp
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end
  initial begin
    logic got;
    logic [71:0] r;
    logic [7:0] ops [3];
    int n;
    logic e;
    ops = '{mpi_pkg::OP_HALT, mpi_pkg::OP_SPIN_L, mpi_pkg::OP_SPIN_R};
    do_reset();
    accum = 32'h0000_1234;
    mv(mpi_pkg::KIND_FIXED, 8'h00, 32'h0000_1234);
    target_reached = 1'b1;
    @(negedge clk_sys);
    target_reached = 1'b0;
    @(negedge clk_sys);
    chk_val(32'(move_busy), 32'h0);
    accum = 32'h7FFF_FFFF;
    actual_pos = 32'h0000_0002;
    mv(mpi_pkg::KIND_OFFSET, 8'h00, 32'h8000_0001);
    mv(mpi_pkg::KIND_POINT, 8'h05, 32'hC0DE_0005);
    chk_val(32'(stored_point_kind_idx), 32'h5);
    for (int i = 0; i < 3; i++) begin
      mv(mpi_pkg::KIND_FIXED, 8'hFF, 32'h7FFF_FFFF);
      cmd(ops[i], 8'h00, 8'h00, 32'h1357_9BDF, mpi_pkg::ST_OK, 32'h1357_9BDF, 1'b1);
      chk_val(32'(move_busy), 32'h0);
    end
    n = ap_cnt;
    cmd(mpi_pkg::OP_MOVE_ACC, 8'h03, 8'h00, 32'h0, mpi_pkg::ST_BAD_TYPE, 32'h0, 1'b0);
    chk_val(32'(ap_cnt), 32'(n));
    u_mpi_host_model.slow = 3;
    accum = 32'h0000_0C80;
    cmd(mpi_pkg::OP_SPIN_L_ACC, 8'h07, 8'h09, 32'hFFFF_0000, mpi_pkg::ST_OK, accum, 1'b1);
    u_mpi_host_model.slow = 0;
    chk_val({ap_idx_q, ap_data_q[23:0]}, {mpi_pkg::AP_TGT_VEL, 24'h000C80});
    chk_val({29'h0, vel_mode, spin_left, move_busy}, 32'h6);
    cmd(mpi_pkg::OP_CALL, 8'h00, 8'h00, 32'h5, mpi_pkg::ST_BAD_CMD, 32'h0, 1'b0);
    chk_val(32'(stk_level), 32'h0);
    u_mpi_host_model.send({mpi_pkg::MOD_ADDR, mpi_pkg::OP_HALT, 48'h0}, 1'b1);
    u_mpi_host_model.recv(got, r);
    chk_val(32'(got), 32'h0);
    for (int s = 0; s < 2; s++) begin
      {flag_zero, flag_equal, flag_above} = s ? 3'h1 : 3'h6;
      err_flags = s ? 4'hA : 4'h5;
      for (int c = 0; c < 13; c++) begin
        do_reset();
        for (int i = 0; i < 32; i++) pmem[i] = {8'h00, mpi_pkg::OP_HALT, 48'h0};
        pmem[0] = call_cmd(4'(c), 16'h0010);
        run_prog(2);
        e = cond_exp(c);
        chk_val(32'(flog[1]), e ? 32'h10 : 32'h1);
        chk_val(32'(stk_level), 32'(e));
      end
    end
    do_reset();
    {flag_zero, flag_equal, flag_above} = 3'h4;
    for (int i = 0; i < 9; i++) pmem[2*i] = call_cmd(mpi_pkg::COND_IS_NULL, 16'(2*i+2));
    pmem[16] = call_cmd(mpi_pkg::COND_IS_NULL, 16'h001E);
    run_prog(10);
    chk_val(32'(flog[8]), 32'h10);
    chk_val(32'(flog[9]), 32'h11);
    chk_val(32'(stk_level), 32'(mpi_pkg::STK_DEPTH));
    // return lands on the command after the branch, stack empties again
    do_reset();
    for (int i = 0; i < 32; i++) pmem[i] = {8'h00, mpi_pkg::OP_HALT, 48'h0};
    pmem[0] = call_cmd(mpi_pkg::COND_IS_NULL, 16'h0010);
    pmem[16] = {8'h00, mpi_pkg::OP_RET, 48'h0};
    run_prog(3);
    chk_val(32'(flog[1]), 32'h10);
    chk_val(32'(flog[2]), 32'h1);
    chk_val(32'(stk_level), 32'h0);
    conclude();
  end
endmodule : tb_motion_program_interpreter
